/* verilog/trig_seq_ctrl.sv */
/*
  Trigger and sequence-advance controller: trigger source and slope selection,
  triggered runs, re-trigger delay, backplane trigger drive and step table playback.
  Assumes all inputs are synchronous to CLK_I and a waveform engine that repeats
  SEG_O while PLAY_O is high and pulses WAVE_END_I at the end of every segment cycle.
*/
`timescale 1ns/100ps
module trig_seq_ctrl #(
  parameter int RETRIG_MAX_CYC = trig_seq_pkg::RETRIG_MAX_CYC
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [31:0] RDATA_O,
  input wire logic EXT_TRIG_I,
  input wire logic [7:0] BP_TRIG_I,
  output logic [7:0] BP_TRIG_O,
  output logic [7:0] BP_TRIG_OE_O,
  input wire logic WAVE_END_I,
  output logic PLAY_O,
  output logic START_O,
  output logic [trig_seq_pkg::SEG_W-1:0] SEG_O
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PLAY = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  localparam logic [trig_seq_pkg::DELAY_W-1:0] DLY_MIN = trig_seq_pkg::DELAY_W'(trig_seq_pkg::RETRIG_MIN_CYC);
  localparam logic [trig_seq_pkg::DELAY_W-1:0] DLY_MAX = trig_seq_pkg::DELAY_W'(RETRIG_MAX_CYC);

  // Register file
  logic [9:0] ctrl_q;
  logic [9:0] ctrl_d;
  logic [trig_seq_pkg::DELAY_W-1:0] delay_q;
  logic [trig_seq_pkg::DELAY_W-1:0] delay_d;
  logic [7:0] tout_q;
  logic [7:0] tout_d;
  logic [4:0] len_q;
  logic [4:0] len_d;
  logic bus_trig_q;
  logic bus_trig_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [trig_seq_pkg::SEG_W-1:0] tab_seg [trig_seq_pkg::STEPS];
  logic [trig_seq_pkg::LOOP_W-1:0] tab_loop [trig_seq_pkg::STEPS];

  // Sequencer state
  state_t state_q;
  state_t state_d;
  logic [trig_seq_pkg::IDX_W-1:0] cur_q;
  logic [trig_seq_pkg::IDX_W-1:0] cur_d;
  logic [trig_seq_pkg::IDX_W-1:0] ptr_q;
  logic [trig_seq_pkg::IDX_W-1:0] ptr_d;
  logic [trig_seq_pkg::LOOP_W-1:0] loops_q;
  logic [trig_seq_pkg::LOOP_W-1:0] loops_d;
  logic [trig_seq_pkg::SEG_W-1:0] seg_q;
  logic [trig_seq_pkg::SEG_W-1:0] seg_d;
  logic play_q;
  logic play_d;
  logic start_q;
  logic start_d;
  logic [7:0] bp_out_q;
  logic [7:0] bp_out_d;
  logic prev_q;
  logic timer_load;
  logic timer_cancel;
  logic timer_done;

  // Decoded control fields
  logic triggered;
  logic retrig_en;
  logic slope_neg;
  logic seq_en;
  logic [3:0] src;
  logic [1:0] adv;
  logic [3:0] bp_idx;
  logic src_lvl;
  logic edge_hit;
  logic trig;
  logic go;
  logic [trig_seq_pkg::IDX_W-1:0] last_idx;
  logic [trig_seq_pkg::IDX_W-1:0] idx;
  logic [trig_seq_pkg::IDX_W-1:0] nxt;
  logic [trig_seq_pkg::DELAY_W-1:0] wr_delay;

  assign triggered = ctrl_q[trig_seq_pkg::CTRL_TRIGGERED_BIT];
  assign retrig_en = ctrl_q[trig_seq_pkg::CTRL_RETRIG_BIT];
  assign slope_neg = ctrl_q[trig_seq_pkg::CTRL_SLOPE_BIT];
  assign seq_en = ctrl_q[trig_seq_pkg::CTRL_SEQ_BIT];
  assign src = ctrl_q[trig_seq_pkg::CTRL_SRC_LSB +: 4];
  assign adv = ctrl_q[trig_seq_pkg::CTRL_ADV_LSB +: 2];
  assign bp_idx = src - trig_seq_pkg::SRC_BP0;
  assign last_idx = (len_q == 5'h00) ? 4'h0 : 4'(len_q - 5'h01);
  assign wr_delay = WDATA_I[trig_seq_pkg::DELAY_W-1:0];

  // Trigger source, slope and qualification
  always_comb begin
    src_lvl = 1'b0;
    if (src == trig_seq_pkg::SRC_EXT) begin
      src_lvl = EXT_TRIG_I;
    end else if (src >= trig_seq_pkg::SRC_BP0 && src <= trig_seq_pkg::SRC_BP7) begin
      src_lvl = BP_TRIG_I[bp_idx[2:0]];
    end
    edge_hit = slope_neg ? (prev_q & ~src_lvl) : (~prev_q & src_lvl);
    if (src == trig_seq_pkg::SRC_BUS) begin
      trig = bus_trig_q;
    end else begin
      trig = edge_hit;
    end
  end

  // Register writes and reads
  always_comb begin
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    tout_d = tout_q;
    len_d = len_q;
    bus_trig_d = 1'b0;
    rdata_d = 32'h0000_0000;
    if (WE_I) begin
      case (ADDR_I)
        trig_seq_pkg::ADDR_CTRL: ctrl_d = WDATA_I[9:0];
        trig_seq_pkg::ADDR_TRIG: bus_trig_d = WDATA_I[0];
        trig_seq_pkg::ADDR_DELAY: begin
          if (wr_delay < DLY_MIN) begin
            delay_d = DLY_MIN;
          end else if (wr_delay > DLY_MAX) begin
            delay_d = DLY_MAX;
          end else begin
            delay_d = wr_delay;
          end
        end
        trig_seq_pkg::ADDR_TRIG_OUT: tout_d = WDATA_I[7:0];
        trig_seq_pkg::ADDR_SEQ_LEN: len_d = (WDATA_I[4:0] > 5'h10) ? 5'h10 : WDATA_I[4:0];
        default: ;
      endcase
    end
    if (RE_I) begin
      case (ADDR_I)
        trig_seq_pkg::ADDR_CTRL: rdata_d = {22'h000000, ctrl_q};
        trig_seq_pkg::ADDR_DELAY: rdata_d = {5'h00, delay_q};
        trig_seq_pkg::ADDR_TRIG_OUT: rdata_d = {24'h000000, tout_q};
        trig_seq_pkg::ADDR_SEQ_LEN: rdata_d = {27'h0000000, len_q};
        trig_seq_pkg::ADDR_STATUS: begin
          rdata_d[trig_seq_pkg::STAT_BUSY_BIT] = (state_q == ST_PLAY);
          rdata_d[trig_seq_pkg::STAT_WAIT_BIT] = (state_q == ST_WAIT);
          rdata_d[trig_seq_pkg::STAT_CUR_LSB +: 4] = cur_q;
          rdata_d[trig_seq_pkg::STAT_PTR_LSB +: 4] = ptr_q;
          rdata_d[trig_seq_pkg::STAT_LOOPS_LSB +: trig_seq_pkg::LOOP_W] = loops_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= trig_seq_pkg::CTRL_RST;
      delay_q <= trig_seq_pkg::DELAY_RST;
      tout_q <= trig_seq_pkg::TRIG_OUT_RST;
      len_q <= trig_seq_pkg::SEQ_LEN_RST;
      bus_trig_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      delay_q <= delay_d;
      tout_q <= tout_d;
      len_q <= len_d;
      bus_trig_q <= bus_trig_d;
      rdata_q <= rdata_d;
      prev_q <= src_lvl;
    end
  end

  // Step table storage
  always_ff @(posedge CLK_I) begin
    if (WE_I && ADDR_I == trig_seq_pkg::ADDR_STEP_WR) begin
      tab_seg[WDATA_I[trig_seq_pkg::STEP_IDX_LSB +: 4]] <= WDATA_I[trig_seq_pkg::STEP_SEG_LSB +: 8];
      tab_loop[WDATA_I[trig_seq_pkg::STEP_IDX_LSB +: 4]] <= WDATA_I[trig_seq_pkg::STEP_LOOP_LSB +: 20];
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    ptr_d = ptr_q;
    loops_d = loops_q;
    seg_d = seg_q;
    play_d = play_q;
    start_d = 1'b0;
    bp_out_d = 8'h00;
    timer_load = 1'b0;
    timer_cancel = 1'b0;
    go = 1'b0;
    nxt = cur_q + 4'h1;
    idx = (seq_en && adv != trig_seq_pkg::ADV_AUTO) ? ptr_q : 4'h0;
    case (state_q)
      ST_IDLE: go = triggered ? trig : 1'b1;
      ST_WAIT: begin
        if (!triggered || !retrig_en) begin
          state_d = ST_IDLE;
          timer_cancel = 1'b1;
        end else begin
          go = timer_done;
        end
      end
      ST_PLAY: begin
        if (WAVE_END_I) begin
          if (loops_q > 20'h00001) begin
            loops_d = loops_q - 20'h00001;
          end else if (seq_en && adv == trig_seq_pkg::ADV_AUTO && cur_q != last_idx) begin
            cur_d = nxt;
            seg_d = tab_seg[nxt];
            loops_d = (tab_loop[nxt] == '0) ? 20'h00001 : tab_loop[nxt];
            start_d = 1'b1;
          end else begin
            play_d = 1'b0;
            if (seq_en && adv != trig_seq_pkg::ADV_AUTO) begin
              ptr_d = (cur_q == last_idx) ? 4'h0 : nxt;
            end
            if (triggered && retrig_en) begin
              state_d = ST_WAIT;
              timer_load = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        play_d = 1'b0;
      end
    endcase
    if (go) begin
      state_d = ST_PLAY;
      cur_d = idx;
      seg_d = tab_seg[idx];
      if (!seq_en || adv == trig_seq_pkg::ADV_SINGLE) begin
        loops_d = 20'h00001;
      end else begin
        loops_d = (tab_loop[idx] == '0) ? 20'h00001 : tab_loop[idx];
      end
      play_d = 1'b1;
      start_d = 1'b1;
      bp_out_d = tout_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_IDLE;
      cur_q <= 4'h0;
      ptr_q <= 4'h0;
      loops_q <= 20'h00000;
      seg_q <= 8'h00;
      play_q <= 1'b0;
      start_q <= 1'b0;
      bp_out_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      ptr_q <= ptr_d;
      loops_q <= loops_d;
      seg_q <= seg_d;
      play_q <= play_d;
      start_q <= start_d;
      bp_out_q <= bp_out_d;
    end
  end

  retrig_timer u_timer (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .load_i(timer_load),
    .cancel_i(timer_cancel),
    .value_i(delay_q),
    .done_o(timer_done)
  );

  assign RDATA_O = rdata_q;
  assign BP_TRIG_O = bp_out_q;
  assign BP_TRIG_OE_O = bp_out_q;
  assign PLAY_O = play_q;
  assign START_O = start_q;
  assign SEG_O = seg_q;
endmodule : trig_seq_ctrl

/* verilog/trig_seq_pkg.sv */
/*
  Shared constants for the trigger and sequence-advance controller:
  register offsets, field positions, reset values, encodings and timing counts.
  Assumes a 10 MHz system clock.
*/
package trig_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_TRIG_OUT = 8'h0c;
  localparam logic [7:0] ADDR_SEQ_LEN = 8'h10;
  localparam logic [7:0] ADDR_STEP_WR = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Control register fields
  localparam int CTRL_TRIGGERED_BIT = 0;
  localparam int CTRL_RETRIG_BIT = 1;
  localparam int CTRL_SLOPE_BIT = 2;
  localparam int CTRL_SEQ_BIT = 3;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_ADV_LSB = 8;
  localparam logic [9:0] CTRL_RST = 10'h000;

  // Trigger source codes
  localparam logic [3:0] SRC_BUS = 4'h0;
  localparam logic [3:0] SRC_EXT = 4'h1;
  localparam logic [3:0] SRC_BP0 = 4'h2;
  localparam logic [3:0] SRC_BP7 = 4'h9;

  // Advance modes
  localparam logic [1:0] ADV_AUTO = 2'h0;
  localparam logic [1:0] ADV_STEP = 2'h1;
  localparam logic [1:0] ADV_SINGLE = 2'h2;

  // Sequence table
  localparam int STEPS = 16;
  localparam int IDX_W = 4;
  localparam int SEG_W = 8;
  localparam int LOOP_W = 20;
  localparam int STEP_IDX_LSB = 0;
  localparam int STEP_SEG_LSB = 4;
  localparam int STEP_LOOP_LSB = 12;
  localparam logic [4:0] SEQ_LEN_RST = 5'h01;
  localparam logic [7:0] TRIG_OUT_RST = 8'h00;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_CUR_LSB = 4;
  localparam int STAT_PTR_LSB = 8;
  localparam int STAT_LOOPS_LSB = 12;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RETRIG_MIN_NS = 1000;
  localparam int RETRIG_MAX_S = 10;
  localparam int DELAY_W = 27;
  localparam int RETRIG_MIN_CYC = (RETRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint RETRIG_MAX_CYC_L = (longint'(RETRIG_MAX_S) * 64'd1000000000) / CLK_PERIOD_NS;
  localparam int RETRIG_MAX_CYC = int'(RETRIG_MAX_CYC_L);
  localparam logic [DELAY_W-1:0] DELAY_RST = DELAY_W'(RETRIG_MIN_CYC);
endpackage : trig_seq_pkg

/* verilog/retrig_timer.sv */
/*
  Down counter for the re-trigger delay.
  Assumes load and cancel come from the controller in the same clock domain.
*/
`timescale 1ns/100ps
module retrig_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic cancel_i,
  input wire logic [trig_seq_pkg::DELAY_W-1:0] value_i,
  output logic done_o
);
  logic [trig_seq_pkg::DELAY_W-1:0] cnt_q;
  logic [trig_seq_pkg::DELAY_W-1:0] cnt_d;
  logic done_q;
  logic done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (load_i) begin
      cnt_d = value_i;
    end else if (cancel_i) begin
      cnt_d = '0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == {{(trig_seq_pkg::DELAY_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
endmodule : retrig_timer

/* verif/trig_src_model.sv */
/*
  Far-side model: front-panel trigger level and eight backplane lines.
  Assumes one level change per request, asked right after a rising edge.
*/
`timescale 1ns/100ps
module trig_src_model (
  input wire logic clk_i,
  input wire logic flip_i,
  input wire logic [3:0] line_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  output logic ext_o,
  output logic [7:0] bp_o
);
  logic [8:0] lvl_q = 9'h000;
  // Edges of either sense on any one line
  always @(posedge clk_i) begin
    if (flip_i) begin
      lvl_q[line_i] <= ~lvl_q[line_i];
    end
  end
  assign ext_o = lvl_q[0];
  // Device drive wins on its enabled lines
  assign bp_o = (oe_i & drv_i) | (~oe_i & lvl_q[8:1]);
endmodule : trig_src_model

/* verif/trig_seq_ctrl_props.sv */
/*
  Port assertions for trig_seq_ctrl, bound to each instance.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module trig_seq_ctrl_props #(
  parameter int RETRIG_MAX_CYC = 200
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RE_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [7:0] BP_TRIG_O,
  input wire logic [7:0] BP_TRIG_OE_O,
  input wire logic WAVE_END_I,
  input wire logic PLAY_O,
  input wire logic START_O,
  input wire logic [trig_seq_pkg::SEG_W-1:0] SEG_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  AST_START_PLAY: assert property (START_O |-> PLAY_O)
    else $error("start outside play");
  AST_PLAY_BEGIN: assert property ($rose(PLAY_O) |-> START_O)
    else $error("play rose without start");
  AST_RUN_END: assert property ($fell(PLAY_O) |-> $past(WAVE_END_I))
    else $error("play fell without wave end");
  AST_SEG_HOLD: assert property (PLAY_O && !START_O |-> $stable(SEG_O))
    else $error("segment moved mid step");
  AST_OE_MATCH: assert property (BP_TRIG_OE_O == BP_TRIG_O)
    else $error("enable differs from drive");
  AST_DRIVE_START: assert property (BP_TRIG_O != 8'h00 |-> START_O && $rose(PLAY_O))
    else $error("line drive off run start");
  AST_DRIVE_PULSE: assert property (BP_TRIG_O != 8'h00 |=> (BP_TRIG_O == 8'h00) [*2])
    else $error("line drive too long");
  AST_READ_QUIET: assert property (!$past(RE_I) |-> RDATA_O == 32'h0)
    else $error("read data without read");
  cover property (START_O && $past(PLAY_O));
  cover property (BP_TRIG_O != 8'h00);
  cover property ($fell(PLAY_O));
endmodule : trig_seq_ctrl_props
bind trig_seq_ctrl trig_seq_ctrl_props #(.RETRIG_MAX_CYC(RETRIG_MAX_CYC)) props (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .BP_TRIG_O(BP_TRIG_O), .BP_TRIG_OE_O(BP_TRIG_OE_O),
  .WAVE_END_I(WAVE_END_I), .PLAY_O(PLAY_O), .START_O(START_O), .SEG_O(SEG_O));

/* verif/trig_seq_ctrl_bench.sv */
/*
  Self-checking bench of trig_seq_ctrl with random runs.
  Assumes the package, the checker and the source model.
*/
`timescale 1ns/100ps
module trig_seq_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, wend = 1'b0, flip = 1'b0;
  logic [7:0] addr = 8'h00, bpo, bpoe, bpi, seg, bp_seen, tseg[3], segs[$];
  logic [31:0] wdata = 32'h0, rdata, rng = 32'h000148ca;
  logic [3:0] line = 4'h0;
  logic ext, play, start;
  int tloop[3], miscompares = 0, check_count = 0, n_start, n_end, cyc, end_cyc, gap, wlen = 2, wcnt;
  always #50 clk = ~clk;
  trig_seq_ctrl #(.RETRIG_MAX_CYC(200)) dut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WE_I(we), .RE_I(re), .RDATA_O(rdata), .EXT_TRIG_I(ext), .BP_TRIG_I(bpi), .BP_TRIG_O(bpo),
    .BP_TRIG_OE_O(bpoe), .WAVE_END_I(wend), .PLAY_O(play), .START_O(start), .SEG_O(seg));
  trig_src_model src (.clk_i(clk), .flip_i(flip), .line_i(line), .drv_i(bpo), .oe_i(bpoe), .ext_o(ext), .bp_o(bpi));
  // Waveform engine stand-in and run monitor
  always @(posedge clk) begin
    wend <= 1'b0;
    cyc <= cyc + 1;
    if (start) wcnt <= wlen;
    else if (play) wcnt <= (wcnt == 0) ? wlen : wcnt - 1;
    if (play && !start && wcnt == 0) wend <= 1'b1;
    if (!rst && start) begin
      n_start <= n_start + 1;
      segs.push_back(seg);
      gap <= cyc - end_cyc;
      if (bpo !== 8'h00) bp_seen <= bpo;
    end
    if (!rst && wend && play) begin
      n_end <= n_end + 1;
      end_cyc <= cyc;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Control word, triggered mode; f is sequence, slope, retrigger
  function automatic logic [31:0] ctl(input logic [3:0] sr, input logic [1:0] adv, input logic [2:0] f);
    return {22'h0, adv, sr, f, 1'b1};
  endfunction : ctl
  function automatic int gap_of(input int n);
    return (n < trig_seq_pkg::RETRIG_MIN_CYC ? trig_seq_pkg::RETRIG_MIN_CYC : n) + 2;
  endfunction : gap_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  task automatic tog(input int l);
    @(posedge clk);
    flip <= 1'b1;
    line <= 4'(l);
    @(posedge clk);
    flip <= 1'b0;
  endtask : tog
  task automatic run_out();
    repeat (4) @(posedge clk);
    for (int k = 0; k < 3000 && play !== 1'b0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask : run_out
  task automatic clr();
    n_start = 0;
    n_end = 0;
    segs.delete();
  endtask : clr
  task automatic go();
    clr();
    wr(trig_seq_pkg::ADDR_TRIG, 32'h1);
    run_out();
  endtask : go
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [31:0] m;
    logic [1:0] am;
    int p, k, tot;
    // Step 0 loaded under reset so the free run after release plays a known segment
    wr(trig_seq_pkg::ADDR_STEP_WR, 32'h0);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i += 1 + (i == 5)) rd(8'(i * 4), i == 2 ? 32'(trig_seq_pkg::DELAY_RST) : 32'(i == 4));
    wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, 2'h0, 3'h0));
    run_out();
    tot = 0;
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      tseg[i] = rng[7:0];
      tloop[i] = 1 + rng[9:8];
      tot += tloop[i];
      wr(trig_seq_pkg::ADDR_STEP_WR, {20'(tloop[i]), tseg[i], 4'(i)});
    end
    rng = xs(rng);
    m = {24'h0, rng[7:0] | 8'h01};
    wlen = 1 + rng[10:8];
    wr(trig_seq_pkg::ADDR_TRIG_OUT, m);
    clr();
    wr(trig_seq_pkg::ADDR_TRIG, 32'h1);
    wr(trig_seq_pkg::ADDR_TRIG, 32'h1);
    run_out();
    chk(n_start, 1);
    chk(n_end, 1);
    chk(segs[0], tseg[0]);
    chk(bp_seen, m);
    wr(trig_seq_pkg::ADDR_TRIG_OUT, 32'h0);
    for (int j = 0; j < 9; j++) begin
      for (int s = 0; s < 2; s++) begin
        wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_EXT + 4'(j), 2'h0, {1'b0, s[0], 1'b0}));
        clr();
        tog((j + 1) % 9);
        tog((j + 1) % 9);
        tog(j);
        run_out();
        chk(n_start, 1 - s);
        tog(j);
        run_out();
        chk(n_start, 1);
      end
    end
    wr(trig_seq_pkg::ADDR_SEQ_LEN, 32'h3);
    for (int r = 0; r < 2; r++) begin
      wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, trig_seq_pkg::ADV_AUTO, 3'h4));
      rng = xs(rng);
      wlen = 1 + rng[1:0];
      go();
      chk(n_start, 3);
      chk(n_end, tot);
      for (int i = 0; i < 3; i++) chk(segs[i], tseg[i]);
    end
    p = 0;
    for (int t = 0; t < 7; t++) begin
      // Code 3 behaves as step advance
      am = t < 4 ? (t == 3 ? 2'h3 : trig_seq_pkg::ADV_STEP) : trig_seq_pkg::ADV_SINGLE;
      wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, am, 3'h4));
      go();
      chk(segs[0], tseg[p]);
      chk(n_end, t < 4 ? tloop[p] : 1);
      p = (p + 1) % 3;
    end
    // Idle after step 0: pointer on step 1, one loop left
    rd(trig_seq_pkg::ADDR_STATUS, (32'h1 << trig_seq_pkg::STAT_LOOPS_LSB) | (32'h1 << trig_seq_pkg::STAT_PTR_LSB));
    for (int r = 0; r < 2; r++) begin
      rng = xs(rng);
      k = r == 0 ? 5 : 10 + rng[5:0];
      wr(trig_seq_pkg::ADDR_DELAY, 32'(k));
      wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, 2'h0, 3'h1));
      clr();
      wr(trig_seq_pkg::ADDR_TRIG, 32'h1);
      for (int w = 0; w < 3000 && n_start < 3; w++) @(posedge clk);
      #1;
      chk(gap, gap_of(k));
      wr(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, 2'h0, 3'h0));
      run_out();
    end
    rd(trig_seq_pkg::ADDR_DELAY, 32'(k));
    rd(trig_seq_pkg::ADDR_CTRL, ctl(trig_seq_pkg::SRC_BUS, 2'h0, 3'h0));
    report_and_stop();
  end
endmodule : trig_seq_ctrl_bench
